/* File: src/dmag_top.sv */
// Purpose: data memory address generator of an 8-bit core
// Assumes: one operand access per cycle, asynchronous-read data memory
// Notes: registers reached over Avalon-MM, one wait cycle per access
//
// Contract
// - access region is 96 gpr bytes of bank 5 plus 160 sfr bytes
// - region addresses 60h-FFh map to 460h-4FFh
// - access bit one forms address from bank pointer and file field
// - access bit zero ignores bank pointer and uses region map
// - region operand read or written in one cycle, no bank change
// - bank pointer gives upper bits, instruction gives low eight bits
// - writes to unimplemented space dropped, reads there return zero
// - instructions carry an 8-bit file address selecting the source
// - destination bit one writes source, zero writes working register
// - three pointers, each a high and a low byte register
// - each pointer holds a 14-bit target address
// - plain operand uses pointer target, pointer unchanged
// - indirect access reaches any bank regardless of bank pointer
// - post-decrement uses target then decreases pointer by one
// - post-increment uses target then increases pointer by one
// - pre-increment raises pointer first then uses new target
// - offset operand adds signed working value to pointer
// - offset operand leaves working register and pointer unchanged
// - steps act on whole pair, low byte carries into high byte
// - pointer steps alter no status flag
// - extended set bit enables literal offset mode via pointer two
`timescale 1ns/100ps
module dmag_top
    import dmag_pkg::*;
#(
    parameter logic [ADDR_W-1:0] IMPL_LAST_ADDR = 14'h0FFF
) (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input wire logic op_valid_in,
    input wire logic [7:0] op_file_in,
    input wire logic op_access_in,
    input wire logic op_dest_in,
    input wire logic op_rd_in,
    input wire logic op_wr_in,
    input wire logic op_last_in,
    input wire logic [DATA_W-1:0] op_result_in,
    input wire logic [DATA_W-1:0] mem_rdata_in,
    input wire logic [5:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic [ADDR_W-1:0] mem_addr_out,
    output logic mem_re_out,
    output logic mem_we_out,
    output logic [DATA_W-1:0] mem_wdata_out,
    output logic [DATA_W-1:0] operand_out,
    output logic operand_valid_out,
    output logic [DATA_W-1:0] work_reg_out
);
    if (IMPL_LAST_ADDR < ACC_GPR_BASE + ADDR_W'(LIT_OFFS_MAX)) begin : g_bad
        $error("implemented space must hold the access region");
    end

    logic [BSR_W-1:0] bsr_r;
    logic ext_r;
    logic [ADDR_W-1:0] last_addr_r;
    logic rd_pend_r;
    logic rd_zero_r;
    dmag_bus_st_t bus_st_r;
    logic [ADDR_W-1:0] ptr_q [3];
    logic [ADDR_W-1:0] dir_addr;
    logic [ADDR_W-1:0] eff_addr;
    logic [ADDR_W-1:0] ptr_sel;
    logic [ADDR_W-1:0] w_sext;
    logic [7:0] vofs;
    logic [1:0] vidx;
    dmag_vop_t vop;
    logic hit;
    logic impl;
    logic op_go;
    logic bus_wr_go;
    logic [31:0] rdata_nxt;

    // ----------------------------------------------------------------
    // file field resolution
    // ----------------------------------------------------------------
    // the 8-bit file field of the opcode feeds the map
    dmag_access_map u_map (
        .file_in(op_file_in),
        .access_in(op_access_in),
        .bsr_in(bsr_r),
        .ext_in(ext_r),
        .ptr2_in(ptr_q[2]),
        .addr_out(dir_addr)
    );

    // ----------------------------------------------------------------
    // virtual operand decode
    // ----------------------------------------------------------------
    // virtual operands sit in the sfr bank and have no storage
    always_comb begin
        vofs = dir_addr[7:0] - VIRT_BASE;
        hit = dir_addr[13:8] == ACC_SFR_BANK && dir_addr[7:0] >= VIRT_BASE
            && vofs < VIRT_SPAN && vofs[2:0] <= VOP_OFFSET_BY_WORKING_OPERAND;
        vidx = vofs[4:3];
        vop = dmag_vop_t'(vofs[2:0]);
    end

    // pointer of the addressed operand group
    always_comb begin
        unique case (vidx)
            2'h0: ptr_sel = ptr_q[0];
            2'h1: ptr_sel = ptr_q[1];
            default: ptr_sel = ptr_q[2];
        endcase
    end

    // effective address: pointer target replaces the operand location
    always_comb begin
        w_sext = {{(ADDR_W - DATA_W){work_reg_out[DATA_W-1]}}, work_reg_out};
        eff_addr = dir_addr;
        if (hit) begin
            unique case (vop)
                VOP_PRE_INCREMENT_OPERAND: eff_addr = ptr_sel + PTR_ONE;
                VOP_OFFSET_BY_WORKING_OPERAND: eff_addr = ptr_sel + w_sext;
                default: eff_addr = ptr_sel;
            endcase
        end
        impl = eff_addr <= IMPL_LAST_ADDR;
        op_go = ce_in && op_valid_in;
    end

    // ----------------------------------------------------------------
    // pointer pairs
    // ----------------------------------------------------------------
    // one pair per pointer; steps only on the final access of an op
    generate
        for (genvar gi = 0; gi < 3; gi++) begin : g_ptr
            localparam logic [5:0] LO_OFS = REG_PTR_LO0
                + 6'(gi) * REG_PTR_STRIDE;
            logic sel;
            logic step;
            logic [ADDR_W-1:0] step_val;
            always_comb begin
                sel = hit && vidx == 2'(gi);
                step = op_valid_in && op_last_in && sel
                    && (vop == VOP_POST_INCREMENT_OPERAND || vop == VOP_POST_DECREMENT_OPERAND
                    || vop == VOP_PRE_INCREMENT_OPERAND);
                step_val = (vop == VOP_POST_DECREMENT_OPERAND) ? ptr_q[gi] - PTR_ONE
                    : ptr_q[gi] + PTR_ONE;
            end
            dmag_ptr_pair #(.PTR_W(ADDR_W)) u_ptr (
                .clock_in(clock_in),
                .sys_rst_in(sys_rst_in),
                .ce_in(ce_in),
                .lo_wr_in(bus_wr_go && avs_address_in == LO_OFS),
                .hi_wr_in(bus_wr_go
                    && avs_address_in == LO_OFS + REG_HI_OFS),
                .wdata_in(avs_writedata_in[7:0]),
                .step_in(step),
                .step_val_in(step_val),
                .ptr_out(ptr_q[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // data memory request
    // ----------------------------------------------------------------
    // one access per cycle; unimplemented space never sees a write
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mem_addr_out <= '0;
            mem_re_out <= 1'b0;
            mem_we_out <= 1'b0;
            mem_wdata_out <= '0;
            last_addr_r <= '0;
        end else if (ce_in) begin
            mem_re_out <= op_valid_in && op_rd_in && impl;
            mem_we_out <= op_valid_in && op_wr_in && op_dest_in
                && impl;
            if (op_valid_in) begin
                mem_addr_out <= eff_addr;
                mem_wdata_out <= op_result_in;
                last_addr_r <= eff_addr;
            end
        end
    end

    // operand return, forced to zero outside implemented space
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rd_pend_r <= 1'b0;
            rd_zero_r <= 1'b0;
            operand_out <= '0;
            operand_valid_out <= 1'b0;
        end else if (ce_in) begin
            rd_pend_r <= op_valid_in && op_rd_in;
            rd_zero_r <= !impl;
            operand_valid_out <= rd_pend_r;
            if (rd_pend_r) begin
                operand_out <= rd_zero_r ? '0 : mem_rdata_in;
            end
        end
    end

    // working register: core result with dest clear, else bus write
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            work_reg_out <= WORK_RST;
        end else if (ce_in) begin
            if (op_valid_in && op_wr_in && !op_dest_in) begin
                work_reg_out <= op_result_in;
            end else if (bus_wr_go && avs_address_in == REG_WORK) begin
                work_reg_out <= avs_writedata_in[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // register bus slave
    // ----------------------------------------------------------------
    // a write lands on the edge where waitrequest is seen low
    assign bus_wr_go = ce_in && avs_write_in && bus_st_r == BUS_ACK
        && avs_byteenable_in[0];

    // read mux; unmapped offsets read zero
    always_comb begin
        rdata_nxt = '0;
        unique case (avs_address_in)
            REG_BSR: rdata_nxt = 32'(bsr_r);
            REG_PTR_LO0: rdata_nxt = 32'(ptr_q[0][7:0]);
            REG_PTR_LO0 + REG_HI_OFS: rdata_nxt = 32'(ptr_q[0][13:8]);
            REG_PTR_LO0 + REG_PTR_STRIDE: rdata_nxt = 32'(ptr_q[1][7:0]);
            REG_PTR_LO0 + REG_PTR_STRIDE + REG_HI_OFS:
                rdata_nxt = 32'(ptr_q[1][13:8]);
            REG_WORK - REG_PTR_STRIDE: rdata_nxt = 32'(ptr_q[2][7:0]);
            REG_WORK - REG_HI_OFS: rdata_nxt = 32'(ptr_q[2][13:8]);
            REG_WORK: rdata_nxt = 32'(work_reg_out);
            REG_CFG: rdata_nxt = 32'(ext_r);
            REG_STAT: rdata_nxt = 32'(last_addr_r);
            default: rdata_nxt = '0;
        endcase
    end

    // handshake: idle with waitrequest high, one answer cycle low
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            bus_st_r <= BUS_IDLE;
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= '0;
        end else if (ce_in) begin
            unique case (bus_st_r)
                BUS_IDLE: begin
                    if (avs_read_in || avs_write_in) begin
                        bus_st_r <= BUS_ACK;
                        avs_waitrequest_out <= 1'b0;
                        avs_readdata_out <= rdata_nxt;
                    end
                end
                BUS_ACK: begin
                    bus_st_r <= BUS_IDLE;
                    avs_waitrequest_out <= 1'b1;
                end
            endcase
        end
    end

    // bank pointer and configuration written by software
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            bsr_r <= BSR_RST;
            ext_r <= 1'b0;
        end else if (bus_wr_go) begin
            if (avs_address_in == REG_BSR) begin
                bsr_r <= avs_writedata_in[BSR_W-1:0];
            end
            if (avs_address_in == REG_CFG) begin
                ext_r <= avs_writedata_in[CFG_EXT_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    logic plain0;
    logic no_bus0;
    assign plain0 = op_go && hit && vidx == 2'h0;
    assign no_bus0 = !(avs_write_in && bus_st_r == BUS_ACK);

    a_dest_work: assert property (
        op_go && op_wr_in && !op_dest_in
        |=> work_reg_out == $past(op_result_in))
        else $error("result not routed to working register");
    a_dest_source: assert property (
        op_go && op_wr_in && op_dest_in && impl
        |=> mem_we_out && mem_wdata_out == $past(op_result_in))
        else $error("result not written back to source");
    a_unimpl_write: assert property (
        mem_we_out |-> mem_addr_out <= IMPL_LAST_ADDR)
        else $error("write reached unimplemented space");
    a_unimpl_read: assert property (
        op_go && op_rd_in && !impl ##1 ce_in
        |=> operand_valid_out && operand_out == '0)
        else $error("unimplemented read not zero");
    a_post_increment_operand_step: assert property (
        plain0 && op_last_in && vop == VOP_POST_INCREMENT_OPERAND && no_bus0
        |=> mem_addr_out == $past(ptr_q[0])
            && ptr_q[0] == $past(ptr_q[0]) + PTR_ONE)
        else $error("post-increment wrong");
    a_post_decrement_operand_step: assert property (
        plain0 && op_last_in && vop == VOP_POST_DECREMENT_OPERAND && no_bus0
        |=> mem_addr_out == $past(ptr_q[0])
            && ptr_q[0] == $past(ptr_q[0]) - PTR_ONE)
        else $error("post-decrement wrong");
    a_pre_increment_operand_addr: assert property (
        plain0 && op_last_in && vop == VOP_PRE_INCREMENT_OPERAND && no_bus0
        |=> mem_addr_out == ptr_q[0])
        else $error("pre-increment target wrong");
    a_offset_by_working_operand_keep: assert property (
        plain0 && vop == VOP_OFFSET_BY_WORKING_OPERAND && no_bus0 && !op_wr_in
        |=> $stable(ptr_q[0]) && $stable(work_reg_out))
        else $error("offset operand changed state");
    a_bank_addr: assert property (
        op_go && op_access_in && !hit
        |=> mem_addr_out == {$past(bsr_r), $past(op_file_in)})
        else $error("banked address wrong");
    a_access_sfr: assert property (
        op_go && !op_access_in && op_file_in >= ACC_SPLIT && !hit
        |=> mem_addr_out == ACC_SFR_BASE + ADDR_W'($past(op_file_in)))
        else $error("access region sfr map wrong");

    c_post_increment_operand: cover property (plain0 && vop == VOP_POST_INCREMENT_OPERAND);
    c_offset_by_working_operand: cover property (plain0 && vop == VOP_OFFSET_BY_WORKING_OPERAND);
    c_bus_write: cover property (bus_wr_go);
    c_unimpl_read: cover property (op_go && op_rd_in && !impl);
endmodule : dmag_top

/* File: src/dmag_pkg.sv */
// Purpose: shared constants and types of the data memory address generator
// Assumes: 14-bit linear data space, 8-bit data, 32-bit register bus
// Notes: register offsets are byte addresses of aligned words
package dmag_pkg;
    // ----------------------------------------------------------------
    // data space layout
    // ----------------------------------------------------------------
    localparam int ADDR_W = 14;
    localparam int BSR_W = 6;
    localparam int DATA_W = 8;
    localparam logic [7:0] ACC_SPLIT = 8'h60;
    localparam logic [7:0] LIT_OFFS_MAX = 8'h5F;
    localparam logic [13:0] ACC_GPR_BASE = 14'h0500;
    localparam logic [13:0] ACC_SFR_BASE = 14'h0400;
    localparam logic [5:0] ACC_SFR_BANK = 6'h04;
    localparam logic [13:0] PTR_ONE = 14'h0001;
    // ----------------------------------------------------------------
    // virtual operands: five per pointer, inside the sfr bank
    // ----------------------------------------------------------------
    localparam logic [7:0] VIRT_BASE = 8'hD0;
    localparam logic [7:0] VIRT_SPAN = 8'h18;
    typedef enum logic [2:0] {
        VOP_PLAIN = 3'h0,
        VOP_POST_INCREMENT_OPERAND = 3'h1,
        VOP_POST_DECREMENT_OPERAND = 3'h2,
        VOP_PRE_INCREMENT_OPERAND = 3'h3,
        VOP_OFFSET_BY_WORKING_OPERAND = 3'h4
    } dmag_vop_t;
    // ----------------------------------------------------------------
    // register map and reset values
    // ----------------------------------------------------------------
    localparam logic [5:0] REG_BSR = 6'h00;
    localparam logic [5:0] REG_PTR_LO0 = 6'h04;
    localparam logic [5:0] REG_HI_OFS = 6'h04;
    localparam logic [5:0] REG_PTR_STRIDE = 6'h08;
    localparam logic [5:0] REG_WORK = 6'h1C;
    localparam logic [5:0] REG_CFG = 6'h20;
    localparam logic [5:0] REG_STAT = 6'h24;
    localparam logic [5:0] BSR_RST = 6'h00;
    localparam logic [13:0] PTR_RST = 14'h0000;
    localparam logic [7:0] WORK_RST = 8'h00;
    localparam int CFG_EXT_BIT = 0;
    // ----------------------------------------------------------------
    // bus slave states
    // ----------------------------------------------------------------
    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } dmag_bus_st_t;
endpackage : dmag_pkg

/* File: src/dmag_access_map.sv */
// Purpose: resolve the 8-bit file field into a 14-bit data address
// Assumes: purely combinational, used inside the top module
// Notes: covers banked, access region and literal offset forms
`timescale 1ns/100ps
module dmag_access_map
    import dmag_pkg::*;
(
    input wire logic [7:0] file_in,
    input wire logic access_in,
    input wire logic [BSR_W-1:0] bsr_in,
    input wire logic ext_in,
    input wire logic [ADDR_W-1:0] ptr2_in,
    output logic [ADDR_W-1:0] addr_out
);
    // ----------------------------------------------------------------
    // address selection
    // ----------------------------------------------------------------
    // banked, literal offset, sfr half or gpr half of the access region
    always_comb begin
        if (access_in) begin
            addr_out = {bsr_in, file_in};
        end else if (ext_in && file_in <= LIT_OFFS_MAX) begin
            addr_out = ptr2_in + ADDR_W'(file_in);
        end else if (file_in >= ACC_SPLIT) begin
            addr_out = ACC_SFR_BASE + ADDR_W'(file_in);
        end else begin
            addr_out = ACC_GPR_BASE + ADDR_W'(file_in);
        end
    end
endmodule : dmag_access_map

/* File: src/dmag_ptr_pair.sv */
// Purpose: one indirect pointer pair held as a whole linear address
// Assumes: bus byte writes take priority over an operand step
// Notes: high byte holds the upper address bits, rest read as zero
`timescale 1ns/100ps
module dmag_ptr_pair
    import dmag_pkg::*;
#(
    parameter int PTR_W = ADDR_W
) (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input wire logic lo_wr_in,
    input wire logic hi_wr_in,
    input wire logic [7:0] wdata_in,
    input wire logic step_in,
    input wire logic [PTR_W-1:0] step_val_in,
    output logic [PTR_W-1:0] ptr_out
);
    // refuse widths that the byte loads cannot fill
    if (PTR_W <= 8 || PTR_W > 16) begin : g_bad_width
        $error("pointer width must be 9 to 16");
    end
    // ----------------------------------------------------------------
    // pointer storage
    // ----------------------------------------------------------------
    // byte loads from software, whole-pair steps from the operands
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ptr_out <= PTR_W'(PTR_RST);
        end else if (ce_in) begin
            if (lo_wr_in) begin
                ptr_out[7:0] <= wdata_in;
            end else if (hi_wr_in) begin
                ptr_out[PTR_W-1:8] <= wdata_in[PTR_W-9:0];
            end else if (step_in) begin
                ptr_out <= step_val_in;
            end
        end
    end
endmodule : dmag_ptr_pair

/* File: tb/dmag_mem_model.sv */
// Purpose: data memory on the far side of the address generator
// Assumes: asynchronous read, write taken on the write pulse
// Notes: unwritten bytes read back a fixed pattern of their address
`timescale 1ns/100ps
module dmag_mem_model
    import dmag_pkg::*;
(
    input wire logic clock_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic we_in,
    input wire logic [DATA_W-1:0] wdata_in,
    output logic [DATA_W-1:0] rdata_out
);
    logic [DATA_W-1:0] store [2**ADDR_W];
    // every byte starts as a pattern of its own address
    initial begin
        for (int i = 0; i < 2**ADDR_W; i++) begin
            store[i] = 8'(i) ^ 8'(i >> 8) ^ 8'hA5;
        end
    end
    // read follows the address with no clock
    assign rdata_out = store[addr_in];
    // byte write on the pulse
    always @(posedge clock_in) begin
        if (we_in === 1'b1) begin
            store[addr_in] <= wdata_in;
        end
    end
endmodule : dmag_mem_model

/* File: tb/tb_data_memory_address_gen.sv */
// Purpose: self-checking bench of the data memory address generator
// Assumes: registers over Avalon-MM, memory model on the far side
// Notes: random bank and file fields from a fixed-seed shift register
`timescale 1ns/100ps
module tb_data_memory_address_gen
    import dmag_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, ov = 0, oa = 0, od = 0, ord = 0;
    logic owr = 0, ol = 0, rd = 0, wr = 0, ce = 1;
    logic [7:0] of = 8'h00, ores = 8'h00, mrd, wd8, opo, wk;
    logic [5:0] ad = 6'h00;
    logic [31:0] wd = 32'h0, rdd, bd, lf = 32'hd193;
    logic wq, re, we, opv;
    logic [ADDR_W-1:0] ma, ga;
    logic [7:0] gop, gwd, f;
    logic gre, gwe, gov;
    int err_total = 0, comparisons = 0, cyc = 0;
    dmag_top dut (.clock_in(clk), .sys_rst_in(rst), .ce_in(ce),
        .op_valid_in(ov), .op_file_in(of), .op_access_in(oa),
        .op_dest_in(od), .op_rd_in(ord), .op_wr_in(owr), .op_last_in(ol),
        .op_result_in(ores), .mem_rdata_in(mrd), .avs_address_in(ad),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(4'hF), .avs_readdata_out(rdd),
        .avs_waitrequest_out(wq), .mem_addr_out(ma), .mem_re_out(re),
        .mem_we_out(we), .mem_wdata_out(wd8), .operand_out(opo),
        .operand_valid_out(opv), .work_reg_out(wk));
    dmag_mem_model mem (.clock_in(clk), .addr_in(ma), .we_in(we),
        .wdata_in(wd8), .rdata_out(mrd));
    // ------------------------------------------------------------
    // clock, timeout and shared tasks
    // ------------------------------------------------------------
    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end
    function automatic logic [7:0] pat(input logic [13:0] a);
        return a[7:0] ^ {2'h0, a[13:8]} ^ 8'hA5;
    endfunction : pat
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
    endfunction : nxt
    task automatic chk(input string n, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        ad <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wq !== 1'b0);
        bd = rdd;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    // one core access, answer captured in cycles one and two
    task automatic op(input logic [7:0] fi, input logic a, r, w, d,
                      input logic [7:0] res);
        @(posedge clk);
        {ov, of, oa, ord, owr, od, ores, ol} <= {1'b1, fi, a, r, w, d, res,
            1'b1};
        @(posedge clk);
        {ov, ord, owr} <= 3'h0;
        #1 {ga, gre, gwe, gwd} = {ma, re, we, wd8};
        @(posedge clk);
        #1 {gop, gov} = {opo, opv};
    endtask : op
    task automatic rdop(input logic [7:0] fi, input logic a,
                        input logic [13:0] e);
        op(fi, a, 1'b1, 1'b0, 1'b1, 8'h00);
        chk("mem_addr", e, ga);
        chk("operand", e > 14'h0FFF ? 8'h00 : pat(e), gop);
        chk("mem_re", e <= 14'h0FFF, gre);
        chk("operand_valid", 1, gov);
    endtask : rdop
    task automatic close_out();
        if (err_total == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        bus(0, REG_BSR, 0);
        chk("bsr_reset", 0, bd);
        bus(0, 6'h30, 0);
        chk("unmapped", 0, bd);
        repeat (8) begin
            lf = nxt(lf);
            f = lf[15:8];
            bus(1, REG_BSR, {28'h0, lf[2:0] == 3'h4, lf[2:0]});
            rdop(f, 1, {2'h0, lf[2:0] == 3'h4, lf[2:0], f});
            if (f >= 8'hD0 && f < 8'hE8) f = f - 8'h30;
            rdop(f, 0, (f < 8'h60 ? 14'h0500 : 14'h0400) + f);
        end
        bus(1, REG_BSR, 32'h3F);
        rdop(8'h12, 1, 14'h3F12);
        bus(1, REG_BSR, 32'h02);
        op(8'hAA, 1, 0, 1, 1, 8'h5C);
        chk("mem_we", {1'b1, 14'h02AA, 8'h5C}, {gwe, ga, gwd});
        op(8'hAA, 1, 0, 1, 0, 8'h3C);
        chk("work_reg", {1'b0, 8'h3C}, {gwe, wk});
        bus(1, REG_PTR_LO0, 32'hFF);
        bus(1, REG_PTR_LO0 + REG_HI_OFS, 32'h01);
        rdop(8'hD1, 0, 14'h01FF);
        rdop(8'hD0, 0, 14'h0200);
        rdop(8'hD2, 0, 14'h0200);
        rdop(8'hD0, 0, 14'h01FF);
        rdop(8'hD3, 0, 14'h0200);
        bus(1, REG_WORK, 32'h80);
        rdop(8'hD4, 0, 14'h0180);
        rdop(8'hD0, 0, 14'h0200);
        bus(0, REG_WORK, 0);
        chk("work_kept", 32'h80, bd);
        ce <= 1'b0;
        op(8'hD1, 0, 1, 0, 1, 8'h00);
        chk("frozen_re", 0, {gre, gov});
        @(posedge clk);
        ce <= 1'b1;
        rdop(8'hD0, 0, 14'h0200);
        bus(1, 6'h10, 32'h0F);
        bus(1, 6'h0C, 32'h30);
        rdop(8'hD8, 0, 14'h0F30);
        bus(1, 6'h18, 32'h0A);
        bus(1, 6'h14, 32'h20);
        bus(1, REG_CFG, 32'h1);
        rdop(8'h10, 0, 14'h0A30);
        rdop(8'h70, 0, 14'h0470);
        bus(0, REG_STAT, 0);
        chk("status", 14'h0470, bd);
        close_out();
    end
endmodule : tb_data_memory_address_gen
